// ---- hw/phy_control_register_port.sv ----
// register port that configures and commands the power-line phy
`timescale 1ns/100ps
module phy_control_register_port import phy_ctrl_pkg::*; #(
  parameter int ADDR_W = 10
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire fixed_gain_t agc_fixed_in,
  output phy_control_t phy_control,
  output logic [DATA_W-1:0] estimation_threshold_field,
  output mem_req_t mem_req,
  output fixed_gain_t fixed_gain,
  output logic write_rejected
);

  // elaboration check on the background address width
  if (ADDR_W < 1 || ADDR_W > BG_ADDR_MAX_W) begin : g_bad_width
    $error("ADDR_W must lie between 1 and BG_ADDR_MAX_W");
  end

  logic [POINTER_W-1:0] phy_memory_pointer;
  logic [DATA_W-1:0] phy_memory_data;
  logic [POINTER_W-1:0] next_pointer;
  logic [DATA_W-1:0] next_data;
  logic [DATA_W-1:0] next_threshold;
  phy_control_t next_control;
  mem_req_t next_mem_req;
  fixed_gain_t next_fixed_gain;
  logic [DATA_W-1:0] next_rdata;
  logic next_rejected;
  logic [2:0] sel;
  logic paths_idle;
  logic config_ok;
  logic is_mem;
  logic is_direct;
  logic ptr_wr;
  logic data_wr;
  logic data_rd;
  logic ctrl_wr;
  logic thr_wr;
  logic ptr_ok;
  logic data_wr_ok;
  logic data_rd_ok;
  logic [MEM_COUNT-1:0][ADDR_W-1:0] bg_addr;
  logic [ADDR_W-1:0] sel_addr;

  // access decode and write permission
  always_comb begin
    sel = phy_memory_pointer[SEL_MSB:SEL_LSB];
    is_mem = (sel == TGT_SYMBOL) || (sel == TGT_FRAMESYNC) || (sel == TGT_TXPHASE);
    is_direct = (sel == TGT_COMM) || (sel == TGT_DEBUG);
    paths_idle = !phy_control.phy_clock_enable;
    config_ok = paths_idle && phy_control.phy_configuration_mode;
    ptr_wr = reg_wr && (reg_addr == OFS_POINTER);
    data_wr = reg_wr && (reg_addr == OFS_DATA);
    data_rd = reg_rd && (reg_addr == OFS_DATA);
    ctrl_wr = reg_wr && (reg_addr == OFS_CONTROL);
    thr_wr = reg_wr && (reg_addr == OFS_THRESHOLD);
    ptr_ok = ptr_wr && config_ok;
    data_wr_ok = data_wr && (is_direct || (is_mem && config_ok));
    data_rd_ok = data_rd && (is_direct || is_mem);
    sel_addr = '0;
    for (int k = 0; k < MEM_COUNT; k++) begin
      if (sel == 3'(TGT_SYMBOL + k)) begin
        sel_addr = bg_addr[k];
      end
    end
  end

  // one background address counter per phy memory
  for (genvar i = 0; i < MEM_COUNT; i++) begin : g_bg
    logic [2:0] code;
    assign code = 3'(TGT_SYMBOL + i);
    bg_address_counter #(.ADDR_W(ADDR_W)) u_bg (
      .core_clk(core_clk),
      .reset(reset),
      .ce(ce),
      .load(ptr_ok && (reg_wdata[SEL_MSB:SEL_LSB] == code)),
      .load_value(reg_wdata[ADDR_W-1:0]),
      .step((data_wr_ok || data_rd_ok) && (sel == code)),
      .addr(bg_addr[i])
    );
  end

  // next register values
  always_comb begin
    next_pointer = phy_memory_pointer;
    next_data = phy_memory_data;
    next_threshold = estimation_threshold_field;
    next_control = phy_control;
    next_control.retransmit_strobe = 1'b0;
    next_control.acknowledge_start_strobe = 1'b0;
    next_rejected = 1'b0;
    if (ptr_ok) begin
      next_pointer = reg_wdata[POINTER_W-1:0];
    end
    if (mem_rvalid) begin
      next_data = mem_rdata;
    end
    if (data_wr_ok) begin
      next_data = reg_wdata;
    end
    if (thr_wr) begin
      next_threshold = reg_wdata;
    end
    if (ctrl_wr) begin
      next_control = phy_control_t'(reg_wdata);
    end
    if ((ptr_wr && !ptr_ok) || (data_wr && !data_wr_ok)) begin
      next_rejected = 1'b1;
    end
  end

  // access towards the phy and fixed gain forwarding
  always_comb begin
    next_mem_req = '0;
    next_mem_req.target = sel;
    next_mem_req.addr = BG_ADDR_MAX_W'(sel_addr);
    next_mem_req.wdata = reg_wdata;
    next_mem_req.write = data_wr_ok;
    next_mem_req.read = data_rd_ok;
    next_fixed_gain = '0;
    if (phy_control.gain_freeze) begin
      next_fixed_gain = agc_fixed_in;
    end
  end

  // read data mux, unmapped offsets read zero
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_POINTER: next_rdata = {3'h0, phy_memory_pointer};
        OFS_DATA: next_rdata = phy_memory_data;
        OFS_THRESHOLD: next_rdata = estimation_threshold_field;
        OFS_CONTROL: next_rdata = phy_control;
        default: next_rdata = '0;
      endcase
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phy_memory_pointer <= RST_POINTER[POINTER_W-1:0];
      phy_memory_data <= RST_DATA;
      estimation_threshold_field <= RST_THRESHOLD;
      phy_control <= phy_control_t'(RST_CONTROL);
      mem_req <= '0;
      fixed_gain <= '0;
      reg_rdata <= '0;
      write_rejected <= 1'b0;
    end else if (ce) begin
      phy_memory_pointer <= next_pointer;
      phy_memory_data <= next_data;
      estimation_threshold_field <= next_threshold;
      phy_control <= next_control;
      mem_req <= next_mem_req;
      fixed_gain <= next_fixed_gain;
      reg_rdata <= next_rdata;
      write_rejected <= next_rejected;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_PTR_LOCKED: assert property (ce && ptr_wr && !config_ok |=> $stable(phy_memory_pointer) && write_rejected)
    else $error("pointer changed while locked");
  AST_PTR_LOAD: assert property (ce && ptr_ok |=> phy_memory_pointer == $past(reg_wdata[POINTER_W-1:0]))
    else $error("pointer write not taken");
  AST_PTR_RESERVED: assert property (ce && reg_rd && reg_addr == OFS_POINTER |=> reg_rdata[15:13] == 3'h0)
    else $error("pointer reserved bits not zero");
  AST_BG_LOAD: assert property (ce && ptr_ok && reg_wdata[SEL_MSB:SEL_LSB] == TGT_SYMBOL
      |=> bg_addr[0] == $past(reg_wdata[ADDR_W-1:0]))
    else $error("background address not loaded");
  AST_BG_STEP: assert property (ce && data_wr_ok && sel == TGT_FRAMESYNC && !ptr_ok
      |=> bg_addr[1] == $past(bg_addr[1]) + 1'b1 && mem_req.write)
    else $error("no post increment after access");
  AST_NO_STEP: assert property (ce && is_direct && !ptr_ok |=> $stable(bg_addr))
    else $error("address moved for direct target");
  AST_DATA_LOCK: assert property (ce && data_wr && is_mem && !config_ok
      |=> !mem_req.write && write_rejected && $stable(bg_addr))
    else $error("locked memory write went through");
  AST_RETX_CLEAR: assert property (ce && phy_control.retransmit_strobe && !ctrl_wr |=> !phy_control.retransmit_strobe)
    else $error("retransmit strobe stuck");
  AST_ACK_PULSE: assert property (ce && ctrl_wr && reg_wdata[1] ##1 ce && !ctrl_wr
      |-> phy_control.acknowledge_start_strobe ##1 !phy_control.acknowledge_start_strobe)
    else $error("ack strobe not one cycle");
  AST_CTRL_WRITE: assert property (ce && ctrl_wr |=> phy_control == phy_control_t'($past(reg_wdata)))
    else $error("control write lost");
  AST_THRESHOLD: assert property (ce && thr_wr |=> estimation_threshold_field == $past(reg_wdata))
    else $error("threshold write lost");
  AST_GAIN_FIXED: assert property (ce && phy_control.gain_freeze |=> fixed_gain == $past(agc_fixed_in))
    else $error("fixed gain not applied");

  // decode, refusal and side effects
  AST_RSVD_TARGET: assert property (ce && (data_wr || data_rd) && !is_mem && !is_direct
      |=> !mem_req.write && !mem_req.read && $stable(bg_addr))
    else $error("reserved target reached the phy");
  AST_COMM_TAKEN: assert property (ce && data_wr && is_direct
      |=> mem_req.write && !write_rejected && phy_memory_data == $past(reg_wdata))
    else $error("direct target write refused");
  AST_DIR_NO_LOAD: assert property (ce && ptr_ok && (reg_wdata[SEL_MSB:SEL_LSB] == TGT_COMM
      || reg_wdata[SEL_MSB:SEL_LSB] == TGT_DEBUG) |=> $stable(bg_addr))
    else $error("direct pointer loaded an address");
  AST_PTR_BG_KEEP: assert property (ce && ptr_wr && !config_ok
      |=> $stable(bg_addr))
    else $error("refused pointer write moved an address");
  AST_REJECT_QUIET: assert property (ce && !(ptr_wr && !ptr_ok) && !(data_wr && !data_wr_ok)
      |=> !write_rejected)
    else $error("reject pulse without a refused write");

  // memory access and background addresses
  AST_WR_DATA: assert property (ce && data_wr_ok
      |=> mem_req.write && mem_req.wdata == $past(reg_wdata) && mem_req.target == $past(sel))
    else $error("memory write request wrong");
  AST_SYM_STEP: assert property (ce && data_rd_ok && sel == TGT_SYMBOL && !ptr_ok
      |=> bg_addr[0] == $past(bg_addr[0]) + 1'b1 && mem_req.read)
    else $error("no post increment after read");
  AST_TXPHASE_ADDR: assert property (ce && (data_wr_ok || data_rd_ok) && sel == TGT_TXPHASE
      |=> mem_req.addr == BG_ADDR_MAX_W'($past(bg_addr[2])))
    else $error("tx phase access at wrong address");
  AST_BG_LOAD_TXPHASE: assert property (ce && ptr_ok && reg_wdata[SEL_MSB:SEL_LSB] == TGT_TXPHASE
      |=> bg_addr[2] == $past(reg_wdata[ADDR_W-1:0]))
    else $error("tx phase address not loaded");
  AST_DATA_CAPTURE: assert property (ce && mem_rvalid && !data_wr_ok
      |=> phy_memory_data == $past(mem_rdata))
    else $error("phy read data not captured");

  // control, threshold and read-back
  AST_ACK_CLEAR: assert property (ce && phy_control.acknowledge_start_strobe && !ctrl_wr
      |=> !phy_control.acknowledge_start_strobe)
    else $error("ack strobe stuck");
  AST_CTRL_KEEP: assert property (ce && !ctrl_wr
      |=> phy_control[15:2] == $past(phy_control[15:2]))
    else $error("control field changed without a write");
  AST_THR_KEEP: assert property (ce && !thr_wr
      |=> $stable(estimation_threshold_field))
    else $error("threshold changed without a write");
  AST_RD_POINTER: assert property (ce && reg_rd && reg_addr == OFS_POINTER
      |=> reg_rdata == {3'h0, $past(phy_memory_pointer)})
    else $error("pointer read back wrong");
  AST_RD_DATA: assert property (ce && reg_rd && reg_addr == OFS_DATA
      |=> reg_rdata == $past(phy_memory_data))
    else $error("data register read back wrong");
  AST_RD_THRESHOLD: assert property (ce && reg_rd && reg_addr == OFS_THRESHOLD
      |=> reg_rdata == $past(estimation_threshold_field))
    else $error("threshold read back wrong");
  AST_RD_CONTROL: assert property (ce && reg_rd && reg_addr == OFS_CONTROL
      |=> reg_rdata == $past(phy_control))
    else $error("control read back wrong");
  AST_GAIN_ZERO: assert property (ce && !phy_control.gain_freeze
      |=> fixed_gain == '0)
    else $error("fixed gain shown while not frozen");

  // reset values and clock enable freeze
  AST_RESET_CLEAR: assert property ($fell(reset)
      |-> phy_memory_pointer == '0 && phy_memory_data == '0
      && estimation_threshold_field == '0 && phy_control == '0)
    else $error("register not clear after reset");
  AST_FROZEN: assert property (!ce
      |=> $stable(phy_control) && $stable(phy_memory_pointer) && $stable(bg_addr) && $stable(reg_rdata))
    else $error("state moved while clock enable low");

  COV_MEM_WRITE: cover property (ce && data_wr_ok && is_mem ##1 ce && data_wr_ok && is_mem);
  COV_REJECT: cover property (ce && ptr_wr && !config_ok);
  COV_RETX: cover property (ce && ctrl_wr && reg_wdata[0]);
  COV_DEBUG_READ: cover property (ce && data_rd_ok && sel == TGT_DEBUG);
  COV_RESERVED: cover property (ce && data_wr && !is_mem && !is_direct);

endmodule

// ---- hw/phy_ctrl_pkg.sv ----
// shared constants and types for the phy control register port
package phy_ctrl_pkg;

  // register port geometry
  localparam int DATA_W = 16;
  localparam int REG_ADDR_W = 4;

  // register offsets
  localparam logic [3:0] OFS_POINTER = 4'h0;
  localparam logic [3:0] OFS_DATA = 4'h1;
  localparam logic [3:0] OFS_THRESHOLD = 4'h2;
  localparam logic [3:0] OFS_CONTROL = 4'h3;

  // reset values
  localparam logic [15:0] RST_POINTER = 16'h0000;
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [15:0] RST_THRESHOLD = 16'h0000;
  localparam logic [15:0] RST_CONTROL = 16'h0000;

  // pointer layout, memory count and gain shift width
  localparam int POINTER_W = 13;
  localparam int SEL_LSB = 10;
  localparam int SEL_MSB = 12;
  localparam int BG_ADDR_MAX_W = 10;
  localparam int MEM_COUNT = 3;
  localparam int GAIN_SHIFT_W = 4;

  // target codes in pointer bits 12:10
  localparam logic [2:0] TGT_COMM = 3'h0;
  localparam logic [2:0] TGT_SYMBOL = 3'h2;
  localparam logic [2:0] TGT_FRAMESYNC = 3'h3;
  localparam logic [2:0] TGT_TXPHASE = 3'h4;
  localparam logic [2:0] TGT_DEBUG = 3'h7;

  // demodulator receive modes
  typedef enum logic [1:0] {RX_AUTO, RX_NORMAL, RX_ROBUST, RX_INVALID} receive_mode_t;

  // control register, bit 15 down to bit 0
  typedef struct packed {
    logic phy_configuration_mode;
    logic crc_enable;
    logic tx_reset_request;
    logic rx_reset_request;
    receive_mode_t receive_mode_field;
    logic gain_freeze;
    logic gain_control_enable;
    logic transmit_robust_enable;
    logic dc_blocker_enable;
    logic jammer_cancel_enable;
    logic jammer_detect_enable;
    logic path_direction_select;
    logic phy_clock_enable;
    logic acknowledge_start_strobe;
    logic retransmit_strobe;
  } phy_control_t;

  // one access towards the phy memories, comm register or debug bus
  typedef struct packed {
    logic [2:0] target;
    logic write;
    logic read;
    logic [BG_ADDR_MAX_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  // fixed gain setting used while gain adjustment is frozen
  typedef struct packed {
    logic fixed_gain_direction;
    logic [GAIN_SHIFT_W-1:0] gain_shift_amount;
  } fixed_gain_t;

endpackage

// ---- hw/bg_address_counter.sv ----
// background address register of one phy memory
`timescale 1ns/100ps
module bg_address_counter import phy_ctrl_pkg::*; #(
  parameter int ADDR_W = 10
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic load,
  input wire logic [ADDR_W-1:0] load_value,
  input wire logic step,
  output logic [ADDR_W-1:0] addr
);

  logic [ADDR_W-1:0] next_addr;

  // load wins over post-increment
  always_comb begin
    next_addr = addr;
    if (load) begin
      next_addr = load_value;
    end else if (step) begin
      next_addr = addr + 1'b1;
    end
  end

  // register, frozen while ce is low
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      addr <= '0;
    end else if (ce) begin
      addr <= next_addr;
    end
  end

endmodule

// ---- testbench/phy_memory_model.sv ----
// behavioural phy memory answering requests of the register port
`timescale 1ns/100ps
module phy_memory_model import phy_ctrl_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire mem_req_t mem_req,
  output logic [DATA_W-1:0] mem_rdata,
  output logic mem_rvalid
);
  logic [DATA_W-1:0] store [0:1023];

  // store writes, answer reads one cycle later; line scrambles between answers
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_rvalid <= 1'b0;
      mem_rdata <= 16'h0000;
    end else begin
      if (mem_req.write) begin
        store[mem_req.addr] <= mem_req.wdata;
      end
      mem_rvalid <= mem_req.read;
      mem_rdata <= mem_req.read ? store[mem_req.addr] : ~mem_rdata;
    end
  end
endmodule

// ---- testbench/phy_control_register_port_tb.sv ----
// self-checking bench for the phy control register port
`timescale 1ns/100ps
module phy_control_register_port_tb;
  import phy_ctrl_pkg::*;
  logic core_clk, reset, ce, reg_wr, reg_rd, mem_rvalid, write_rejected;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, mem_rdata, estimation_threshold_field, q, v;
  fixed_gain_t agc_fixed_in, fixed_gain;
  phy_control_t phy_control;
  mem_req_t mem_req;
  int err_count = 0;
  int check_count = 0;

  phy_control_register_port u_phy_control_register_port (.core_clk(core_clk), .reset(reset), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .agc_fixed_in(agc_fixed_in), .phy_control(phy_control),
    .estimation_threshold_field(estimation_threshold_field), .mem_req(mem_req), .fixed_gain(fixed_gain),
    .write_rejected(write_rejected));
  phy_memory_model u_phy_memory_model (.core_clk(core_clk), .reset(reset), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one register write, effects visible on return
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk) #1;
    reg_wr = 1'b0;
  endtask

  // one register read, data sampled in the answer cycle
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk) #1;
    reg_rd = 1'b0;
    q = reg_rdata;
  endtask

  // all registers clear, unmapped offset reads zero
  task automatic t_reset;
    for (int a = 0; a < 5; a++) begin
      rd(4'(a));
      chk(q, 0);
    end
    $display("test reset done");
  endtask

  // control bits and receive modes auto, normal and robust, with gain frozen
  task automatic t_control;
    for (int m = 0; m < 3; m++) begin
      v = 16'h03FC | 16'(m << 10);
      wr(OFS_CONTROL, v);
      chk(phy_control, v);
      rd(OFS_CONTROL);
      chk(q, v);
      chk(fixed_gain, agc_fixed_in);
    end
    wr(OFS_CONTROL, 16'h0000);
    rd(OFS_CONTROL);
    chk(fixed_gain, 0);
    $display("test control done");
  endtask

  // strobes stand exactly one cycle
  task automatic t_strobe;
    wr(OFS_CONTROL, 16'h0003);
    chk(phy_control[1:0], 2'h3);
    @(posedge core_clk) #1;
    chk(phy_control[1:0], 2'h0);
    $display("test strobe done");
  endtask

  // threshold read and write
  task automatic t_threshold;
    wr(OFS_THRESHOLD, 16'hA5C3);
    chk(estimation_threshold_field, 16'hA5C3);
    rd(OFS_THRESHOLD);
    chk(q, 16'hA5C3);
    $display("test threshold done");
  endtask

  // clock enable low: a write is not taken, state holds
  task automatic t_freeze;
    @(posedge core_clk) #1;
    ce = 1'b0;
    wr(OFS_THRESHOLD, 16'h0F0F);
    chk(estimation_threshold_field, 16'hA5C3);
    ce = 1'b1;
    rd(OFS_THRESHOLD);
    chk(q, 16'hA5C3);
    $display("test freeze done");
  endtask

  // memory write with increment, then read back through prefetch
  task automatic t_memory;
    wr(OFS_CONTROL, 16'h8000);
    wr(OFS_POINTER, 16'hE805);
    rd(OFS_POINTER);
    chk(q, 16'h0805);
    wr(OFS_DATA, 16'hABCD);
    chk(mem_req, {3'h2, 1'b1, 1'b0, 10'h005, 16'hABCD});
    wr(OFS_DATA, 16'h1234);
    chk(mem_req, {3'h2, 1'b1, 1'b0, 10'h006, 16'h1234});
    wr(OFS_POINTER, 16'h0805);
    rd(OFS_DATA);
    chk({mem_req.target, mem_req.read, mem_req.addr}, {3'h2, 1'b1, 10'h005});
    repeat (3) @(posedge core_clk);
    rd(OFS_DATA);
    chk(q, 16'hABCD);
    $display("test memory done");
  endtask

  // writes refused while the phy runs change nothing
  task automatic t_refuse;
    wr(OFS_CONTROL, 16'h0004);
    wr(OFS_DATA, 16'h5555);
    chk({write_rejected, mem_req.write}, 2'h2);
    wr(OFS_POINTER, 16'h0C01);
    chk(write_rejected, 1'b1);
    rd(OFS_POINTER);
    chk(q, 16'h0805);
    $display("test refuse done");
  endtask

  // comm register taken with phy running, address stays put
  task automatic t_comm;
    wr(OFS_CONTROL, 16'h8000);
    wr(OFS_POINTER, 16'h0003);
    wr(OFS_CONTROL, 16'h0004);
    wr(OFS_DATA, 16'h1111);
    chk(mem_req, {3'h0, 1'b1, 1'b0, 10'h000, 16'h1111});
    wr(OFS_DATA, 16'h2222);
    chk(mem_req, {3'h0, 1'b1, 1'b0, 10'h000, 16'h2222});
    chk(write_rejected, 1'b0);
    $display("test comm done");
  endtask

  // frame sync, tx phase, debug and a reserved target code
  task automatic t_targets;
    wr(OFS_CONTROL, 16'h8000);
    wr(OFS_POINTER, 16'h0C10);
    wr(OFS_DATA, 16'h0001);
    wr(OFS_DATA, 16'h0002);
    chk(mem_req, {3'h3, 1'b1, 1'b0, 10'h011, 16'h0002});
    wr(OFS_POINTER, 16'h1020);
    wr(OFS_DATA, 16'h0003);
    chk(mem_req, {3'h4, 1'b1, 1'b0, 10'h020, 16'h0003});
    wr(OFS_POINTER, 16'h1C00);
    rd(OFS_DATA);
    chk({mem_req.target, mem_req.read, mem_req.addr}, {3'h7, 1'b1, 10'h000});
    wr(OFS_POINTER, 16'h0400);
    wr(OFS_DATA, 16'h0004);
    chk({write_rejected, mem_req.write}, 2'h2);
    rd(OFS_DATA);
    chk(mem_req.read, 1'b0);
    $display("test targets done");
  endtask

  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    #20000;
    err_count++;
    end_sim();
  end

  // main sequence
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    agc_fixed_in = 5'h15;
    repeat (2) @(posedge core_clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_control();
    t_strobe();
    t_threshold();
    t_freeze();
    t_memory();
    t_refuse();
    t_comm();
    t_targets();
    end_sim();
  end
endmodule
